/* shared/bms_pkg.sv */
// bms_pkg: shared constants and carrier structs for the barrier mode/alarm supervisor.
// assumes a single 125 MHz system clock; all panel inputs already synchronous.
package bms_pkg;
    // clock rate and timing figures in their own units
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 1000;
    localparam int HORN_S = 3;
    localparam int PRESENCE_S = 15;
    localparam int BACK_LOOP_MS = 500;
    // derived cycle counts
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int BACK_LOOP_CYC = CLK_HZ / 1000 * BACK_LOOP_MS;
    // horn and persistence counts are in one-second ticks; lamps swap once per tick
    localparam int HORN_TICKS = HORN_S * 1000 / TICK_MS;
    localparam int PRESENCE_TICKS = PRESENCE_S * 1000 / TICK_MS;

    // master panel mode selector encoding
    typedef enum logic [1:0] {
        BMS_MODE_EMERG = 2'b00,
        BMS_MODE_TEST = 2'b01,
        BMS_MODE_LOCAL = 2'b10
    } bms_mode_e;

    // traffic signal states
    typedef enum logic [1:0] {
        BMS_SIG_DARK = 2'b00,
        BMS_SIG_RED = 2'b01,
        BMS_SIG_GREEN = 2'b10
    } bms_sig_e;

    // mode indicator lamps at the panels
    typedef struct packed {
        logic emerg;
        logic test;
        logic local_lamp;
    } bms_mode_lamp_s;

    // fault inputs that raise a red lamp and an alarm
    typedef struct packed {
        logic comm_loss;
        logic tamper;
        logic loop_fault;
        logic power_fault;
    } bms_fault_s;
endpackage : bms_pkg

/* rtl/bms_supervisor.sv */
// bms_supervisor: mode conflict, out-of-service, return-to-emergency and alarm logic
// for one barrier lane. assumes all inputs synchronous to sys_clk, asynchronous reset.
//
// Overview of operation
// - emergency+local conflict blocks emergency and local
// - that conflict alternates emergency/local lamps, sounds alarm
// - test+local conflict: signal red, test disabled
// - that conflict alternates test/local lamps, sounds alarm
// - out-of-service locks out all barrier functions
// - out-of-service alternates open/closed lamps each second
// - out-of-service in local/test: red, pavement lights
// - out-of-service in emergency: signal dark, locked
// - switch inactive leaves controls normal
// - return to emergency, all open: dark, pavement off
// - return with barrier closed: stay red, trouble alarm
// - that case flashes emergency and open lamps
// - back loop delayed half a second
// - silence mutes horn only, new alarms resound, except a fault while another fault already stands
// - emergency operate button sounds alarm
// - overspeed or wrong-way sounds three seconds
// - presence lamp now, alarm after persistence period
// - entering out-of-service sounds three seconds
// - power/loop faults raise alarm with lamp
// - communication loss raises alarm and lamp
// - tamper switch raises alarm and lamp
// - local horn silenceable, only in local mode
// - beacons on at close command until green
`timescale 1ns/10ps
module bms_supervisor #(
    parameter int TICK_CYCLES = bms_pkg::TICK_CYC,
    parameter int BACK_CYCLES = bms_pkg::BACK_LOOP_CYC,
    parameter int PRESENCE_TICKS = bms_pkg::PRESENCE_TICKS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire bms_pkg::bms_mode_e master_mode,
    input wire logic local_sel,
    input wire logic out_of_service,
    input wire logic barrier_open,
    input wire logic all_dir_open,
    input wire logic test_open_cmd,
    input wire logic test_close_cmd,
    input wire logic local_open_cmd,
    input wire logic local_close_cmd,
    input wire logic emergency_fast_operate,
    input wire logic overspeed,
    input wire logic wrong_way,
    input wire logic front_loop,
    input wire logic back_loop,
    input wire bms_pkg::bms_fault_s faults,
    input wire logic silence_btn,
    input wire logic local_silence_btn,
    input wire logic green_req,
    output bms_pkg::bms_mode_lamp_s mode_lamps,
    output bms_pkg::bms_sig_e signal_state,
    output logic pavement_on,
    output logic open_lamp,
    output logic closed_lamp,
    output logic presence_lamp,
    output bms_pkg::bms_fault_s fault_lamps,
    output logic trouble_alarm,
    output logic horn,
    output logic local_horn,
    output logic beacons_on,
    output logic emergency_enable,
    output logic barrier_open_cmd,
    output logic barrier_close_cmd,
    output logic loop_occupied
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int BW = $clog2(BACK_CYCLES + 1);
    localparam int VW = $clog2(PRESENCE_TICKS + 1);
    localparam int HW = $clog2(bms_pkg::HORN_TICKS + 1);

    // common tick and flash phase
    logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic phase_reg, phase_next;
    // timers and edge memories
    logic [BW-1:0] back_cnt_reg, back_cnt_next;
    logic [VW-1:0] pres_cnt_reg, pres_cnt_next;
    logic [HW-1:0] pulse_cnt_reg, pulse_cnt_next;
    logic oos_d_reg, pf_d_reg;
    logic [1:0] ev_d_reg;
    logic [5:0] cond_d_reg;
    logic muted_reg, muted_next;
    logic lmuted_reg, lmuted_next;
    logic beacon_reg, beacon_next;
    logic red_reg, red_next;
    // output flops
    bms_pkg::bms_mode_lamp_s lamps_next;
    bms_pkg::bms_sig_e sig_next;
    logic pav_next, open_l_next, closed_l_next, pres_l_next, trouble_next;
    logic horn_next, lhorn_next, emerg_en_next, ocmd_next, ccmd_next, occ_next;

    // decoded conditions
    logic in_local, conf_el, conf_tl, oos_rise, event_rise, pulse_start;
    logic back_ok, pres_alarm, ret_bad, close_cmd, any_fault;
    logic [5:0] cond_now;

    always_comb begin
        in_local = local_sel;
        conf_el = (master_mode == bms_pkg::BMS_MODE_EMERG) && in_local;
        conf_tl = (master_mode == bms_pkg::BMS_MODE_TEST) && in_local;
        oos_rise = out_of_service && !oos_d_reg;
        event_rise = (overspeed && !ev_d_reg[0]) || (wrong_way && !ev_d_reg[1]);
        pulse_start = oos_rise || event_rise;
        back_ok = (back_cnt_reg == BW'(BACK_CYCLES));
        pres_alarm = (pres_cnt_reg == VW'(PRESENCE_TICKS));
        ret_bad = (master_mode == bms_pkg::BMS_MODE_EMERG) && !in_local
                  && !all_dir_open && red_reg;
        any_fault = |faults;
        close_cmd = (emergency_fast_operate && emergency_enable)
                    || ccmd_next;
        cond_now = {conf_el, conf_tl, ret_bad, any_fault, pres_alarm,
                    emergency_fast_operate};
    end

    // tick generator: lamps swap once per tick, about once a second
    always_comb begin
        tick_next = 1'b0;
        tick_cnt_next = tick_cnt_reg + TW'(1);
        if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
            tick_cnt_next = '0;
            tick_next = 1'b1;
        end
        phase_next = tick_reg ? !phase_reg : phase_reg;
    end

    // timers: back loop settle, presence persistence, three second pulse
    always_comb begin
        back_cnt_next = !back_loop ? '0 : (back_ok ? back_cnt_reg : back_cnt_reg + BW'(1));
        pres_cnt_next = pres_cnt_reg;
        if (!(front_loop || back_loop)) begin
            pres_cnt_next = '0;
        end else if (tick_reg && !pres_alarm) begin
            pres_cnt_next = pres_cnt_reg + VW'(1);
        end
        pulse_cnt_next = pulse_cnt_reg;
        if (pulse_start) begin
            pulse_cnt_next = HW'(bms_pkg::HORN_TICKS);
        end else if (tick_reg && pulse_cnt_reg != '0) begin
            pulse_cnt_next = pulse_cnt_reg - HW'(1);
        end
    end

    // operating commands, signals and lamps
    always_comb begin
        emerg_en_next = (master_mode == bms_pkg::BMS_MODE_EMERG) && !in_local
                        && !out_of_service;
        ocmd_next = 1'b0;
        ccmd_next = 1'b0;
        if (!out_of_service && !conf_el && !conf_tl) begin
            if (master_mode == bms_pkg::BMS_MODE_TEST) begin
                ocmd_next = test_open_cmd;
                ccmd_next = test_close_cmd;
            end else if (master_mode == bms_pkg::BMS_MODE_LOCAL && in_local) begin
                ocmd_next = local_open_cmd;
                ccmd_next = local_close_cmd;
            end
        end
        occ_next = front_loop || back_ok;
        // red latch: non-emergency modes go red, emergency returns dark only when clear
        red_next = red_reg;
        if (master_mode != bms_pkg::BMS_MODE_EMERG || in_local) begin
            red_next = 1'b1;
        end else if (all_dir_open) begin
            red_next = 1'b0;
        end
        if (out_of_service && master_mode == bms_pkg::BMS_MODE_EMERG && !in_local) begin
            sig_next = bms_pkg::BMS_SIG_DARK;
        end else if (red_next || out_of_service) begin
            sig_next = bms_pkg::BMS_SIG_RED;
        end else if (green_req) begin
            sig_next = bms_pkg::BMS_SIG_GREEN;
        end else begin
            sig_next = bms_pkg::BMS_SIG_DARK;
        end
        pav_next = (sig_next == bms_pkg::BMS_SIG_RED);
        trouble_next = ret_bad;
        // position lamps: alternate under out-of-service, flash open on bad return
        open_l_next = barrier_open;
        closed_l_next = !barrier_open;
        if (out_of_service) begin
            open_l_next = phase_reg;
            closed_l_next = !phase_reg;
        end else if (ret_bad) begin
            open_l_next = phase_reg;
        end
        lamps_next.emerg = (master_mode == bms_pkg::BMS_MODE_EMERG);
        lamps_next.test = (master_mode == bms_pkg::BMS_MODE_TEST);
        lamps_next.local_lamp = in_local;
        if (conf_el) begin
            lamps_next.emerg = phase_reg;
            lamps_next.local_lamp = !phase_reg;
        end else if (conf_tl) begin
            lamps_next.test = phase_reg;
            lamps_next.local_lamp = !phase_reg;
        end else if (ret_bad) begin
            lamps_next.emerg = phase_reg;
        end
        pres_l_next = front_loop || back_loop;
        // beacons latch on a close command, drop only at green
        beacon_next = beacon_reg;
        if (close_cmd) begin
            beacon_next = 1'b1;
        end else if (signal_state == bms_pkg::BMS_SIG_GREEN) begin
            beacon_next = 1'b0;
        end
    end

    // horns: silence mutes until a new condition rises
    always_comb begin
        muted_next = muted_reg;
        if ((|(cond_now & ~cond_d_reg)) || pulse_start) begin
            muted_next = 1'b0; // new condition wins over silence
        end else if (silence_btn) begin
            muted_next = 1'b1;
        end
        horn_next = !muted_next && ((|cond_now) || pulse_cnt_next != '0);
        lmuted_next = lmuted_reg;
        if (faults.power_fault && !pf_d_reg) begin // own edge, not any fault
            lmuted_next = 1'b0;
        end else if (local_silence_btn) begin
            lmuted_next = 1'b1;
        end
        lhorn_next = in_local && !lmuted_next && faults.power_fault;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
            phase_reg <= 1'b0;
            back_cnt_reg <= '0;
            pres_cnt_reg <= '0;
            pulse_cnt_reg <= '0;
            oos_d_reg <= 1'b0;
            pf_d_reg <= 1'b0;
            ev_d_reg <= '0;
            cond_d_reg <= '0;
            muted_reg <= 1'b0;
            lmuted_reg <= 1'b0;
            beacon_reg <= 1'b0;
            red_reg <= 1'b1;
            mode_lamps <= '0;
            signal_state <= bms_pkg::BMS_SIG_RED;
            pavement_on <= 1'b1; // lit with the red reset signal
            open_lamp <= 1'b0;
            closed_lamp <= 1'b0;
            presence_lamp <= 1'b0;
            fault_lamps <= '0;
            trouble_alarm <= 1'b0;
            horn <= 1'b0;
            local_horn <= 1'b0;
            beacons_on <= 1'b0;
            emergency_enable <= 1'b0;
            barrier_open_cmd <= 1'b0;
            barrier_close_cmd <= 1'b0;
            loop_occupied <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            phase_reg <= phase_next;
            back_cnt_reg <= back_cnt_next;
            pres_cnt_reg <= pres_cnt_next;
            pulse_cnt_reg <= pulse_cnt_next;
            oos_d_reg <= out_of_service;
            pf_d_reg <= faults.power_fault;
            ev_d_reg <= {wrong_way, overspeed};
            cond_d_reg <= cond_now;
            muted_reg <= muted_next;
            lmuted_reg <= lmuted_next;
            beacon_reg <= beacon_next;
            red_reg <= red_next;
            mode_lamps <= lamps_next;
            signal_state <= sig_next;
            pavement_on <= pav_next;
            open_lamp <= open_l_next;
            closed_lamp <= closed_l_next;
            presence_lamp <= pres_l_next;
            fault_lamps <= faults;
            trouble_alarm <= trouble_next;
            horn <= horn_next;
            local_horn <= lhorn_next;
            beacons_on <= beacon_next;
            emergency_enable <= emerg_en_next;
            barrier_open_cmd <= ocmd_next;
            barrier_close_cmd <= ccmd_next;
            loop_occupied <= occ_next;
        end
    end

    // an emergency/local conflict removes emergency and every operating command one cycle later
    a_conflict_lockout: assert property (@(posedge sys_clk) disable iff (rst)
        conf_el |-> ##1 (!emergency_enable && !barrier_open_cmd && !barrier_close_cmd))
        else $error("conflict did not lock out");

    sequence s_oos_enter;
        out_of_service && !oos_d_reg;
    endsequence
    a_oos_horn_start: assert property (@(posedge sys_clk) disable iff (rst)
        s_oos_enter ##0 !silence_btn |-> ##1 horn)
        else $error("out-of-service entry did not sound");

    a_oos_lockout: assert property (@(posedge sys_clk) disable iff (rst)
        out_of_service |-> ##1 (!barrier_open_cmd && !barrier_close_cmd && !emergency_enable))
        else $error("out-of-service left controls live");

    a_oos_lamps_alt: assert property (@(posedge sys_clk) disable iff (rst)
        out_of_service [*2] |-> (open_lamp != closed_lamp))
        else $error("position lamps not alternating");

    a_oos_emerg_dark: assert property (@(posedge sys_clk) disable iff (rst)
        (out_of_service && master_mode == bms_pkg::BMS_MODE_EMERG && !local_sel)
        |=> signal_state == bms_pkg::BMS_SIG_DARK)
        else $error("signal not dark in emergency out-of-service");

    a_pavement_red: assert property (@(posedge sys_clk) disable iff (rst)
        pavement_on == (signal_state == bms_pkg::BMS_SIG_RED))
        else $error("pavement lights disagree with signal");

    a_return_trouble: assert property (@(posedge sys_clk) disable iff (rst)
        ret_bad && !out_of_service |=> (trouble_alarm && signal_state == bms_pkg::BMS_SIG_RED))
        else $error("bad return not red with trouble");

    a_local_horn_mode: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(local_sel) |-> !local_horn)
        else $error("local horn outside local mode");

    a_beacon_hold: assert property (@(posedge sys_clk) disable iff (rst)
        beacons_on && signal_state != bms_pkg::BMS_SIG_GREEN && !close_cmd |=> beacons_on)
        else $error("beacons dropped before green");

    a_tick_phase: assert property (@(posedge sys_clk) disable iff (rst)
        !tick_reg |=> $stable(phase_reg))
        else $error("flash phase moved off tick");
endmodule : bms_supervisor

/* test/bms_barrier_model.sv */
// bms_barrier_model: behavioural barrier power unit and limit switches.
// assumes open/close commands are levels from the supervisor on sys_clk.
`timescale 1ns/10ps
module bms_barrier_model #(
    parameter int TRAVEL = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic open_cmd,
    input wire logic close_cmd,
    output logic barrier_open,
    output logic all_dir_open
);
    int cnt;
    // travel takes a few cycles; the limit drops at once when closing starts
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            barrier_open <= 1'b1;
            cnt <= 0;
        end else if (close_cmd) begin
            barrier_open <= 1'b0;
            cnt <= 0;
        end else if (open_cmd) begin
            cnt <= cnt + 1;
            if (cnt >= TRAVEL) barrier_open <= 1'b1;
        end
    end
    // single barrier in this direction
    assign all_dir_open = barrier_open;
endmodule : bms_barrier_model

/* test/bms_supervisor_bench.sv */
// bms_supervisor_bench: directed scenarios for the lane supervisor.
// assumes short tick, back loop and presence counts set below.
`timescale 1ns/10ps
module bms_supervisor_bench;
    localparam int TK = 10;
    logic sys_clk, rst, local_sel, out_of_service, barrier_open, all_dir_open;
    logic test_open_cmd, test_close_cmd, local_open_cmd, local_close_cmd;
    logic emergency_fast_operate, overspeed, wrong_way, front_loop, back_loop;
    logic silence_btn, local_silence_btn, green_req;
    bms_pkg::bms_mode_e master_mode;
    bms_pkg::bms_fault_s faults, fault_lamps;
    bms_pkg::bms_mode_lamp_s mode_lamps;
    bms_pkg::bms_sig_e signal_state;
    logic pavement_on, open_lamp, closed_lamp, presence_lamp, trouble_alarm, horn;
    logic local_horn, beacons_on, emergency_enable, barrier_open_cmd;
    logic barrier_close_cmd, loop_occupied, prev;
    int err_count = 0;
    int comparisons = 0;
    bms_supervisor #(.TICK_CYCLES(TK), .BACK_CYCLES(4), .PRESENCE_TICKS(3)) u_bms_supervisor (
        .sys_clk(sys_clk), .rst(rst), .master_mode(master_mode), .local_sel(local_sel),
        .out_of_service(out_of_service), .barrier_open(barrier_open),
        .all_dir_open(all_dir_open), .test_open_cmd(test_open_cmd),
        .test_close_cmd(test_close_cmd), .local_open_cmd(local_open_cmd),
        .local_close_cmd(local_close_cmd), .emergency_fast_operate(emergency_fast_operate),
        .overspeed(overspeed), .wrong_way(wrong_way), .front_loop(front_loop),
        .back_loop(back_loop), .faults(faults), .silence_btn(silence_btn),
        .local_silence_btn(local_silence_btn), .green_req(green_req),
        .mode_lamps(mode_lamps), .signal_state(signal_state), .pavement_on(pavement_on),
        .open_lamp(open_lamp), .closed_lamp(closed_lamp), .presence_lamp(presence_lamp),
        .fault_lamps(fault_lamps), .trouble_alarm(trouble_alarm), .horn(horn),
        .local_horn(local_horn), .beacons_on(beacons_on),
        .emergency_enable(emergency_enable), .barrier_open_cmd(barrier_open_cmd),
        .barrier_close_cmd(barrier_close_cmd), .loop_occupied(loop_occupied));
    bms_barrier_model u_bms_barrier_model (.sys_clk(sys_clk), .rst(rst),
        .open_cmd(barrier_open_cmd), .close_cmd(barrier_close_cmd),
        .barrier_open(barrier_open), .all_dir_open(all_dir_open));
    // free-running 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task results;
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    // settle 1 ns past the edge so outputs are stable when read
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    // bounded wait on the horn; running out ends the run
    task wait_horn(input logic v, input int lim, input string m);
        int i;
        i = 0;
        while (horn !== v && i < lim) begin
            step(1);
            i++;
        end
        chk(horn === v, m);
        if (horn !== v) results();
    endtask : wait_horn
    // drop every condition, then silence whatever still sounds
    task quiet;
        @(posedge sys_clk);
        {local_sel, out_of_service, test_open_cmd, test_close_cmd} <= 4'h0;
        {local_open_cmd, local_close_cmd, emergency_fast_operate, overspeed} <= 4'h0;
        {wrong_way, front_loop, back_loop, green_req} <= 4'h0;
        faults <= 4'h0;
        silence_btn <= 1'b1;
        step(2);
        @(posedge sys_clk);
        silence_btn <= 1'b0;
        step(2);
    endtask : quiet
    task t_conflict_emerg;
        @(posedge sys_clk);
        master_mode <= bms_pkg::BMS_MODE_EMERG;
        local_sel <= 1'b1;
        local_open_cmd <= 1'b1;
        step(3);
        chk(emergency_enable === 1'b0, "emergency not blocked");
        chk(barrier_open_cmd === 1'b0, "local panel has control");
        chk(horn === 1'b1, "conflict horn silent");
        chk(mode_lamps.emerg !== mode_lamps.local_lamp, "lamps not alternate");
        prev = mode_lamps.emerg;
        step(TK);
        chk(mode_lamps.emerg !== prev, "conflict lamps not flashing");
        @(posedge sys_clk);
        silence_btn <= 1'b1;
        step(3);
        chk(horn === 1'b0, "silence ignored");
        chk(mode_lamps.emerg !== mode_lamps.local_lamp, "silence hit lamps");
        @(posedge sys_clk);
        silence_btn <= 1'b0;
        master_mode <= bms_pkg::BMS_MODE_TEST;
        test_close_cmd <= 1'b1;
        step(3);
        chk(horn === 1'b1, "new conflict not resounding");
        chk(signal_state === bms_pkg::BMS_SIG_RED, "test conflict not red");
        chk(barrier_close_cmd === 1'b0, "test function active");
        chk(mode_lamps.test !== mode_lamps.local_lamp, "test lamps not alternate");
        quiet();
    endtask : t_conflict_emerg
    task t_oos_test;
        @(posedge sys_clk);
        master_mode <= bms_pkg::BMS_MODE_TEST;
        out_of_service <= 1'b1;
        test_open_cmd <= 1'b1;
        step(3);
        chk(horn === 1'b1, "oos entry horn silent");
        chk(open_lamp !== closed_lamp, "position lamps not alternate");
        chk(signal_state === bms_pkg::BMS_SIG_RED, "oos test not red");
        chk(pavement_on === 1'b1, "pavement lights off");
        chk(barrier_open_cmd === 1'b0, "oos not locked out");
        prev = open_lamp;
        step(TK);
        chk(open_lamp !== prev, "position lamps not flashing");
        wait_horn(1'b0, 8 * TK, "oos horn did not clear");
        @(posedge sys_clk);
        master_mode <= bms_pkg::BMS_MODE_EMERG;
        step(3);
        chk(signal_state === bms_pkg::BMS_SIG_DARK, "oos emerg not dark");
        chk(emergency_enable === 1'b0, "oos emerg not locked");
        quiet();
    endtask : t_oos_test
    task t_return;
        @(posedge sys_clk);
        master_mode <= bms_pkg::BMS_MODE_TEST;
        test_close_cmd <= 1'b1;
        step(4);
        chk(barrier_close_cmd === 1'b1, "test close refused");
        chk(beacons_on === 1'b1, "beacons off on close");
        @(posedge sys_clk);
        test_close_cmd <= 1'b0;
        master_mode <= bms_pkg::BMS_MODE_EMERG;
        step(3);
        chk(signal_state === bms_pkg::BMS_SIG_RED, "closed return not red");
        chk(trouble_alarm === 1'b1, "no trouble alarm");
        prev = mode_lamps.emerg;
        step(TK);
        chk(mode_lamps.emerg !== prev, "emerg lamp not flashing");
        @(posedge sys_clk);
        master_mode <= bms_pkg::BMS_MODE_TEST;
        test_open_cmd <= 1'b1;
        step(8);
        chk(barrier_open === 1'b1, "barrier did not open");
        @(posedge sys_clk);
        test_open_cmd <= 1'b0;
        master_mode <= bms_pkg::BMS_MODE_EMERG;
        step(3);
        chk(signal_state === bms_pkg::BMS_SIG_DARK, "open return not dark");
        chk(pavement_on === 1'b0, "pavement stays on");
        chk(emergency_enable === 1'b1, "emergency not restored");
        chk(beacons_on === 1'b1, "beacons dropped before green");
        @(posedge sys_clk);
        green_req <= 1'b1;
        step(3);
        chk(signal_state === bms_pkg::BMS_SIG_GREEN, "green refused");
        chk(beacons_on === 1'b0, "beacons stay on at green");
        quiet();
    endtask : t_return
    task t_alarms;
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            overspeed <= (k == 0);
            wrong_way <= (k == 1);
            step(2);
            chk(horn === 1'b1, "detection horn silent");
            wait_horn(1'b0, 8 * TK, "detection horn stuck");
            quiet();
        end
        @(posedge sys_clk);
        emergency_fast_operate <= 1'b1;
        step(2);
        chk(horn === 1'b1, "operate button horn silent");
        quiet();
        @(posedge sys_clk);
        front_loop <= 1'b1;
        step(2);
        chk(presence_lamp === 1'b1, "presence lamp late");
        chk(horn === 1'b0, "presence horn early");
        wait_horn(1'b1, 5 * TK, "presence horn missing");
        quiet();
        @(posedge sys_clk);
        back_loop <= 1'b1;
        step(2);
        chk(loop_occupied === 1'b0, "back loop not delayed");
        step(4);
        chk(loop_occupied === 1'b1, "back loop never seen");
        quiet();
        for (int b = 0; b < 4; b++) begin
            @(posedge sys_clk);
            faults <= 4'h1 << b;
            step(2);
            chk(fault_lamps === (4'h1 << b), "fault lamp wrong");
            chk(horn === 1'b1, "fault horn silent");
            quiet();
        end
        @(posedge sys_clk);
        master_mode <= bms_pkg::BMS_MODE_LOCAL;
        local_sel <= 1'b1;
        faults <= 4'h1;
        step(2);
        chk(local_horn === 1'b1, "local horn silent");
        @(posedge sys_clk);
        local_sel <= 1'b0;
        step(2);
        chk(local_horn === 1'b0, "local horn outside local");
        @(posedge sys_clk);
        local_sel <= 1'b1;
        step(2);
        chk(local_horn === 1'b1, "local horn not back in local");
        @(posedge sys_clk);
        local_silence_btn <= 1'b1;
        step(2);
        chk(local_horn === 1'b0, "local silence ignored");
        chk(horn === 1'b1, "local silence muted panel horn");
        @(posedge sys_clk);
        local_silence_btn <= 1'b0;
        quiet();
    endtask : t_alarms
    // main sequence: reset for eleven cycles, then each scenario in turn
    initial begin
        rst = 1'b1;
        master_mode = bms_pkg::BMS_MODE_EMERG;
        {local_sel, out_of_service, test_open_cmd, test_close_cmd} = 4'h0;
        {local_open_cmd, local_close_cmd, emergency_fast_operate, overspeed} = 4'h0;
        {wrong_way, front_loop, back_loop, green_req} = 4'h0;
        {silence_btn, local_silence_btn} = 2'h0;
        faults = 4'h0;
        step(10);
        chk(signal_state === bms_pkg::BMS_SIG_RED, "reset signal not red");
        chk(horn === 1'b0, "reset horn on");
        @(posedge sys_clk);
        rst <= 1'b0;
        step(3);
        t_conflict_emerg();
        t_oos_test();
        t_return();
        t_alarms();
        results();
    end
endmodule : bms_supervisor_bench
